// File: hw/fpe_defs.svh
`ifndef FPE_DEFS_SVH
`define FPE_DEFS_SVH
`define FPE_ADDR_CMD      12'hff8
`define FPE_ADDR_PAGE     12'hff9
`define FPE_ADDR_FREQ_HI  12'hffa
`define FPE_ADDR_FREQ_LO  12'hffb
`define FPE_CMD_RESET     8'h00
`define FPE_CMD_KEY1      8'h73
`define FPE_CMD_KEY2      8'h8c
`define FPE_CMD_ERASE     8'h95
`define FPE_CMD_MASS      8'h63
`define FPE_CMD_SECSEL    8'h5e
`define FPE_ST_LOCKED     6'h00
`define FPE_ST_KEY1       6'h01
`define FPE_ST_KEY2       6'h02
`define FPE_ST_UNLOCKED   6'h03
`define FPE_ST_SECSEL     6'h04
`define FPE_ST_PROG       6'h08
`define FPE_ST_ERASE      6'h10
`define FPE_PROG_US       32'd40
`define FPE_ERASE_US      32'd10000
`define FPE_FREQ_RST      16'h0000
`define FPE_LOCK_RST      8'h00
`endif

// File: hw/fpe_pkg.sv
package fpe_pkg;
  typedef enum logic [2:0] {
    FPE_LOCKED, FPE_PG1, FPE_KEY1, FPE_KEY2, FPE_UNLOCKED, FPE_SECSEL, FPE_PROG, FPE_ERASE
  } fpe_state_t;
endpackage

// File: hw/fpe_timer.sv
`timescale 1ns/1ps
`include "fpe_defs.svh"
// cycle timer: duration_us * khz / 1000 cycles, at least one
module fpe_timer (
  input  wire logic        mclk,     // system clock
  input  wire logic        rst,      // async reset
  input  wire logic        start,    // load pulse
  input  wire logic [31:0] dur_us,   // duration in microseconds
  input  wire logic [15:0] khz,      // clock setting in kilohertz
  output logic             done      // one-cycle end pulse
);
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic [47:0] prod;
  logic [31:0] load;
  logic [47:0] quo;
  logic        run_r;

  // round up so a pulse is never shorter than required
  assign prod = dur_us * {16'h0000, khz} + 48'h0000_0000_03e7;
  assign quo  = prod / 48'h0000_0000_03e8;
  // a zero setting still gives a one-cycle pulse rather than a stuck timer
  assign load = (quo == 48'h0) ? 32'h1 : quo[31:0];
  assign cnt_nxt = start ? load : (run_r ? cnt_r - 32'h1 : cnt_r);
  assign done = run_r && (cnt_r == 32'h1) && !start;

  // countdown
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_r <= 32'h0;
      run_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      run_r <= start | (run_r & (cnt_r != 32'h1));
    end
  end
endmodule

// File: hw/fpe_ctrl.sv
`timescale 1ns/1ps
`include "fpe_defs.svh"
module fpe_ctrl (
  input  wire logic        mclk,          // system clock
  input  wire logic        rst,           // async reset, active high
  input  wire logic        reg_wr,        // register write strobe
  input  wire logic        reg_rd,        // register read strobe
  input  wire logic [11:0] reg_addr,      // register file address
  input  wire logic [7:0]  reg_wdata,     // register write data
  output logic      [7:0]  reg_rdata,     // register read data
  input  wire logic        mem_wr,        // program memory store
  input  wire logic [15:0] mem_addr,      // store address
  input  wire logic [7:0]  mem_wdata,     // store data
  input  wire logic        opt_wprot,     // write protect option
  input  wire logic        opt_rprot,     // read protect option
  input  wire logic        ext_rd_req,    // debugger or bypass read
  output logic             ext_rd_allow,  // external read permitted
  output logic             cpu_stall,     // processor stall
  output logic             irq_hold,      // defer interrupts
  output logic             nvm_prog,      // byte program pulse active
  output logic             nvm_erase,     // page erase pulse active
  output logic      [15:0] nvm_addr,      // array address
  output logic      [7:0]  nvm_wdata,     // programmed byte
  output logic      [7:0]  status         // controller state field
);
  fpe_pkg::fpe_state_t st_r, st_nxt;
  logic [7:0]  page_r;
  logic [7:0]  lock_r;
  logic [15:0] khz_r;
  logic [15:0] addr_r;
  logic [7:0]  data_r;
  logic [7:0]  rdata_r;
  logic        tstart;
  logic        tdone;

  wire wr_cmd   = reg_wr && (reg_addr == `FPE_ADDR_CMD);
  wire wr_page  = reg_wr && (reg_addr == `FPE_ADDR_PAGE);
  wire secsel   = (st_r == fpe_pkg::FPE_SECSEL);
  wire busy     = (st_r == fpe_pkg::FPE_PROG) || (st_r == fpe_pkg::FPE_ERASE);
  wire [2:0] sec_of_page = page_r[6:4];                          // 16 pages per sector
  wire sec_locked = lock_r[sec_of_page];
  wire in_page  = (mem_addr[15:9] == page_r[6:0]);
  wire prog_ok  = (st_r == fpe_pkg::FPE_UNLOCKED) && mem_wr && in_page
                  && !sec_locked && !opt_wprot;
  wire erase_ok = wr_cmd && (reg_wdata == `FPE_CMD_ERASE) && !sec_locked
                  && !opt_wprot;

  // status code from state
  logic [5:0] st_code;
  always_comb begin
    unique case (st_r)
      fpe_pkg::FPE_LOCKED, fpe_pkg::FPE_PG1: st_code = `FPE_ST_LOCKED;
      fpe_pkg::FPE_KEY1:     st_code = `FPE_ST_KEY1;
      fpe_pkg::FPE_KEY2:     st_code = `FPE_ST_KEY2;
      fpe_pkg::FPE_UNLOCKED: st_code = `FPE_ST_UNLOCKED;
      fpe_pkg::FPE_SECSEL:   st_code = `FPE_ST_SECSEL;
      fpe_pkg::FPE_PROG:     st_code = `FPE_ST_PROG;
      fpe_pkg::FPE_ERASE:    st_code = `FPE_ST_ERASE;
    endcase
  end
  assign status = {2'b00, st_code};

  // unlock sequencer; writes while busy are ignored since the core is stalled
  always_comb begin
    st_nxt = st_r;
    tstart = 1'b0;
    unique case (st_r)
      fpe_pkg::FPE_LOCKED: begin
        if (wr_cmd && reg_wdata == `FPE_CMD_SECSEL) st_nxt = fpe_pkg::FPE_SECSEL;
        else if (wr_page) st_nxt = fpe_pkg::FPE_PG1;
      end
      fpe_pkg::FPE_PG1: begin
        if (wr_cmd) begin
          if (reg_wdata == `FPE_CMD_KEY1) st_nxt = fpe_pkg::FPE_KEY1;
          else if (reg_wdata == `FPE_CMD_SECSEL) st_nxt = fpe_pkg::FPE_SECSEL;
          else st_nxt = fpe_pkg::FPE_LOCKED;
        end
      end
      fpe_pkg::FPE_KEY1: begin
        if (wr_cmd && reg_wdata == `FPE_CMD_KEY2) st_nxt = fpe_pkg::FPE_KEY2;
        else if (wr_cmd || wr_page) st_nxt = fpe_pkg::FPE_LOCKED;
      end
      fpe_pkg::FPE_KEY2: begin
        if (wr_page && reg_wdata == page_r) st_nxt = fpe_pkg::FPE_UNLOCKED;
        else if (wr_cmd || wr_page) st_nxt = fpe_pkg::FPE_LOCKED;
      end
      fpe_pkg::FPE_UNLOCKED: begin
        if (erase_ok) begin
          st_nxt = fpe_pkg::FPE_ERASE;
          tstart = 1'b1;
        end else if (wr_cmd || wr_page) begin
          st_nxt = fpe_pkg::FPE_LOCKED;
        end else if (prog_ok) begin
          st_nxt = fpe_pkg::FPE_PROG;
          tstart = 1'b1;
        end
      end
      fpe_pkg::FPE_SECSEL: begin
        if (wr_cmd && reg_wdata != `FPE_CMD_SECSEL) st_nxt = fpe_pkg::FPE_LOCKED;
      end
      fpe_pkg::FPE_PROG: begin
        if (tdone) st_nxt = fpe_pkg::FPE_UNLOCKED;          // stays open for more bytes
      end
      fpe_pkg::FPE_ERASE: begin
        if (tdone) st_nxt = fpe_pkg::FPE_LOCKED;
      end
    endcase
  end

  // state and registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r   <= fpe_pkg::FPE_LOCKED;
      page_r <= 8'h00;
      lock_r <= `FPE_LOCK_RST;
      khz_r  <= `FPE_FREQ_RST;
    end else begin
      st_r <= st_nxt;
      if (wr_page && secsel) lock_r <= lock_r | reg_wdata;
      if (wr_page && !secsel && !busy && st_r != fpe_pkg::FPE_KEY2) page_r <= reg_wdata;
      if (reg_wr && reg_addr == `FPE_ADDR_FREQ_HI) khz_r[15:8] <= reg_wdata;
      if (reg_wr && reg_addr == `FPE_ADDR_FREQ_LO) khz_r[7:0] <= reg_wdata;
    end
  end

  // captured store for the program pulse
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      addr_r <= 16'h0000;
      data_r <= 8'hff;
    end else if (tstart) begin
      addr_r <= prog_ok && !erase_ok ? mem_addr : {page_r[6:0], 9'h000};
      data_r <= mem_wdata;
    end
  end

  // read mux; data is registered so reads return one cycle after the strobe
  wire [7:0] rd_mux = (reg_addr == `FPE_ADDR_CMD)     ? status :
                      (reg_addr == `FPE_ADDR_PAGE)    ? (secsel ? lock_r : page_r) :
                      (reg_addr == `FPE_ADDR_FREQ_HI) ? khz_r[15:8] :
                      (reg_addr == `FPE_ADDR_FREQ_LO) ? khz_r[7:0] : 8'h00;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) rdata_r <= 8'h00;
    else if (reg_rd) rdata_r <= rd_mux;
  end
  assign reg_rdata = rdata_r;

  // durations scale with the kilohertz setting
  fpe_timer u_timer (
    .mclk   (mclk),
    .rst    (rst),
    .start  (tstart),
    .dur_us ((st_nxt == fpe_pkg::FPE_ERASE) ? `FPE_ERASE_US : `FPE_PROG_US),
    .khz    (khz_r),
    .done   (tdone)
  );

  // array drive; program word is the captured store byte, passed to the array unmerged
  assign nvm_prog     = (st_r == fpe_pkg::FPE_PROG);
  assign nvm_erase    = (st_r == fpe_pkg::FPE_ERASE);
  assign nvm_addr     = addr_r;
  assign nvm_wdata    = data_r;
  assign cpu_stall    = busy;
  assign irq_hold     = busy;
  assign ext_rd_allow = ext_rd_req && !opt_rprot;

  property p_reset_locked;
    @(posedge mclk) $fell(rst) |-> status == 8'h00;
  endproperty
  a_reset_locked: assert property (p_reset_locked) else $error("not locked after reset");

  property p_lock_sticky;
    @(posedge mclk) disable iff (rst) (lock_r & $past(lock_r)) == $past(lock_r);
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock bit cleared");

  property p_no_prog_locked;
    @(posedge mclk) disable iff (rst) $rose(nvm_prog) |-> !$past(sec_locked) && !$past(opt_wprot);
  endproperty
  a_no_prog_locked: assert property (p_no_prog_locked) else $error("program in locked sector");

  property p_erase_relock;
    @(posedge mclk) disable iff (rst) $fell(nvm_erase) |-> status == 8'h00;
  endproperty
  a_erase_relock: assert property (p_erase_relock) else $error("no relock after erase");

  property p_stall;
    @(posedge mclk) disable iff (rst) (status == 8'h08 || status == 8'h10) |-> cpu_stall && irq_hold;
  endproperty
  a_stall: assert property (p_stall) else $error("cpu not stalled");

  property p_secsel;
    @(posedge mclk) disable iff (rst)
      ((status == 8'h00 || status == 8'h04) && wr_cmd && reg_wdata == `FPE_CMD_SECSEL && !busy)
      |=> status == 8'h04;
  endproperty
  a_secsel: assert property (p_secsel) else $error("sector select missed");

  property p_reset_cmd;
    @(posedge mclk) disable iff (rst)
      (wr_cmd && reg_wdata == `FPE_CMD_RESET && !busy) |=> status == 8'h00;
  endproperty
  a_reset_cmd: assert property (p_reset_cmd) else $error("reset command did not relock");

  sequence s_key2;
    status == 8'h02;
  endsequence
  property p_unlock;
    @(posedge mclk) disable iff (rst) s_key2 ##0 (wr_page && reg_wdata == page_r)
      |=> status == 8'h03;
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock failed");

  property p_rprot;
    @(posedge mclk) disable iff (rst) opt_rprot |-> !ext_rd_allow;
  endproperty
  a_rprot: assert property (p_rprot) else $error("protected read allowed");

  // the unlock chain is checked key by key so a skipped step shows where it happens
  property p_key1;
    @(posedge mclk) disable iff (rst)
      (st_r == fpe_pkg::FPE_PG1 && wr_cmd && reg_wdata == `FPE_CMD_KEY1) |=> status == 8'h01;
  endproperty
  a_key1: assert property (p_key1) else $error("first key not taken");

  property p_key2;
    @(posedge mclk) disable iff (rst)
      (st_r == fpe_pkg::FPE_KEY1 && wr_cmd && reg_wdata == `FPE_CMD_KEY2) |=> status == 8'h02;
  endproperty
  a_key2: assert property (p_key2) else $error("second key not taken");

  // any command that breaks the chain after the first key drops back to locked
  property p_bad_cmd;
    @(posedge mclk) disable iff (rst)
      ((st_r == fpe_pkg::FPE_KEY1 && wr_cmd && reg_wdata != `FPE_CMD_KEY2) ||
       (st_r == fpe_pkg::FPE_KEY2 && wr_cmd)) |=> status == 8'h00;
  endproperty
  a_bad_cmd: assert property (p_bad_cmd) else $error("bad command kept chain");

  property p_bad_page_key1;
    @(posedge mclk) disable iff (rst) (st_r == fpe_pkg::FPE_KEY1 && wr_page) |=> status == 8'h00;
  endproperty
  a_bad_page_key1: assert property (p_bad_page_key1) else $error("early page kept chain");

  property p_bad_page_key2;
    @(posedge mclk) disable iff (rst)
      (st_r == fpe_pkg::FPE_KEY2 && wr_page && reg_wdata != page_r) |=> status == 8'h00;
  endproperty
  a_bad_page_key2: assert property (p_bad_page_key2) else $error("wrong page unlocked");

  sequence s_open;
    st_r == fpe_pkg::FPE_UNLOCKED;
  endsequence
  sequence s_store_in;
    mem_wr && in_page && !wr_cmd && !wr_page;
  endsequence

  // a page write while open is out of order, the page cannot move under an open window
  property p_open_page;
    @(posedge mclk) disable iff (rst) s_open ##0 wr_page |=> status == 8'h00;
  endproperty
  a_open_page: assert property (p_open_page) else $error("page moved while open");

  property p_mass;
    @(posedge mclk) disable iff (rst)
      s_open ##0 (wr_cmd && reg_wdata == `FPE_CMD_MASS) |=> status == 8'h00 && !nvm_erase;
  endproperty
  a_mass: assert property (p_mass) else $error("whole-array erase accepted");

  property p_prog_start;
    @(posedge mclk) disable iff (rst) s_open ##0 s_store_in ##0 (!sec_locked && !opt_wprot)
      |=> status == 8'h08 && nvm_prog && nvm_addr == $past(mem_addr) && nvm_wdata == $past(mem_wdata);
  endproperty
  a_prog_start: assert property (p_prog_start) else $error("store did not program");

  property p_prog_blocked;
    @(posedge mclk) disable iff (rst) s_open ##0 s_store_in ##0 (sec_locked || opt_wprot)
      |=> status == 8'h03 && !nvm_prog;
  endproperty
  a_prog_blocked: assert property (p_prog_blocked) else $error("protected store programmed");

  property p_outside;
    @(posedge mclk) disable iff (rst)
      s_open ##0 (mem_wr && !in_page && !wr_cmd && !wr_page) |=> status == 8'h03 && !nvm_prog;
  endproperty
  a_outside: assert property (p_outside) else $error("store outside page programmed");

  property p_erase_start;
    @(posedge mclk) disable iff (rst) s_open ##0 erase_ok
      |=> status == 8'h10 && nvm_erase && nvm_addr[15:9] == $past(page_r[6:0]) && nvm_addr[8:0] == 9'h000;
  endproperty
  a_erase_start: assert property (p_erase_start) else $error("erase did not start");

  property p_erase_blocked;
    @(posedge mclk) disable iff (rst)
      s_open ##0 (wr_cmd && reg_wdata == `FPE_CMD_ERASE && (sec_locked || opt_wprot))
      |=> status == 8'h00 && !nvm_erase;
  endproperty
  a_erase_blocked: assert property (p_erase_blocked) else $error("protected page erased");

  // the core must get its bus back the cycle after the pulse ends
  property p_prog_back;
    @(posedge mclk) disable iff (rst) (nvm_prog && tdone) |=> status == 8'h03 && !cpu_stall;
  endproperty
  a_prog_back: assert property (p_prog_back) else $error("stall outlived program");

  sequence s_erase_last;
    nvm_erase && tdone;
  endsequence
  property p_erase_done;
    @(posedge mclk) disable iff (rst) s_erase_last |=> status == 8'h00 && !cpu_stall && !irq_hold;
  endproperty
  a_erase_done: assert property (p_erase_done) else $error("erase end not relocked");

  property p_erase_hold;
    @(posedge mclk) disable iff (rst) (nvm_erase && !tdone) |=> nvm_erase && irq_hold;
  endproperty
  a_erase_hold: assert property (p_erase_hold) else $error("erase cut short");

  // sector lock bits only accumulate; a zero written never opens a sector
  property p_w1s;
    @(posedge mclk) disable iff (rst)
      (secsel && wr_page) |=> lock_r == ($past(lock_r) | $past(reg_wdata));
  endproperty
  a_w1s: assert property (p_w1s) else $error("lock write not set-only");

  property p_lock_read;
    @(posedge mclk) disable iff (rst)
      (reg_rd && reg_addr == `FPE_ADDR_PAGE && secsel) |=> reg_rdata == $past(lock_r);
  endproperty
  a_lock_read: assert property (p_lock_read) else $error("lock bits not readable");

  property p_deselect;
    @(posedge mclk) disable iff (rst)
      (secsel && wr_cmd && reg_wdata != `FPE_CMD_SECSEL) |=> status == 8'h00 && !secsel;
  endproperty
  a_deselect: assert property (p_deselect) else $error("sector lock not deselected");

  property p_status_read;
    @(posedge mclk) disable iff (rst)
      (reg_rd && reg_addr == `FPE_ADDR_CMD) |=> reg_rdata == $past(status);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");

  property p_freq_hi;
    @(posedge mclk) disable iff (rst)
      (reg_wr && reg_addr == `FPE_ADDR_FREQ_HI) |=> khz_r[15:8] == $past(reg_wdata);
  endproperty
  a_freq_hi: assert property (p_freq_hi) else $error("clock setting not loaded");
endmodule

// File: tb/fpe_core.sv
`timescale 1ns/1ps
// core model: one-cycle register accesses and stores, never while stalled
module fpe_core (
  input  wire logic        mclk,       // system clock
  input  wire logic        cpu_stall,  // stall from controller
  output logic             reg_wr,     // register write
  output logic             reg_rd,     // register read
  output logic      [11:0] reg_addr,   // register address
  output logic      [7:0]  reg_wdata,  // register data
  output logic             mem_wr,     // memory store
  output logic      [15:0] mem_addr,   // store address
  output logic      [7:0]  mem_wdata,  // store data
  output logic             hung        // stall never ended
);
  initial begin
    {reg_wr, reg_rd, mem_wr, hung} = 4'h0;
    {reg_addr, reg_wdata, mem_addr, mem_wdata} = 44'h0;
  end
  // a stalled core issues nothing, so wait out the stall first
  task automatic settle();
    int n;
    n = 0;
    @(negedge mclk);
    while (cpu_stall !== 1'b0 && n < 3000) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 3000) hung <= 1'b1;
    @(posedge mclk);
  endtask
  // released lines show the inverse so stale values never look valid
  task automatic rg(input logic wr, input logic [11:0] a, input logic [7:0] d);
    settle();
    reg_wr <= wr;
    reg_rd <= !wr;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic st(input logic [15:0] a, input logic [7:0] d);
    settle();
    mem_wr <= 1'b1;
    mem_addr <= a;
    mem_wdata <= d;
    @(posedge mclk);
    mem_wr <= 1'b0;
    mem_addr <= ~a;
    mem_wdata <= ~d;
  endtask
endmodule

// File: tb/flash_program_erase_ctrl_tb.sv
`timescale 1ns/1ps
`include "fpe_defs.svh"
module flash_program_erase_ctrl_tb;
  logic        mclk, rst, opt_wprot, opt_rprot, ext_rd_req, rd_seen;
  logic        reg_wr, reg_rd, mem_wr, hung, ext_rd_allow, cpu_stall, irq_hold;
  logic        nvm_prog, nvm_erase;
  logic [11:0] reg_addr;
  logic [7:0]  reg_wdata, mem_wdata, reg_rdata, nvm_wdata, status, pd, dat;
  logic [15:0] mem_addr, nvm_addr, pa;
  logic [6:0]  ep, pg;
  logic [8:0]  off;
  logic [7:0]  expq[$];
  int          err_total, checks_done, prog_cyc, erase_cyc, hold_cyc, c0, e0, h0;

  fpe_core i_core (.mclk(mclk), .cpu_stall(cpu_stall), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .mem_wr(mem_wr), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .hung(hung));
  fpe_ctrl i_dut (.mclk(mclk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .mem_wr(mem_wr),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .opt_wprot(opt_wprot),
    .opt_rprot(opt_rprot), .ext_rd_req(ext_rd_req), .ext_rd_allow(ext_rd_allow),
    .cpu_stall(cpu_stall), .irq_hold(irq_hold), .nvm_prog(nvm_prog),
    .nvm_erase(nvm_erase), .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata), .status(status));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("counts: %0d checks, %0d mismatches", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    expq.push_back(e);
    i_core.rg(1'b0, a, 8'h00);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    i_core.rg(1'b1, a, d);
  endtask
  task automatic unlock(input logic [6:0] p);
    wr(`FPE_ADDR_CMD, `FPE_CMD_RESET);
    wr(`FPE_ADDR_PAGE, {1'b0, p});
    wr(`FPE_ADDR_CMD, `FPE_CMD_KEY1);
    wr(`FPE_ADDR_CMD, `FPE_CMD_KEY2);
    wr(`FPE_ADDR_PAGE, {1'b0, p});
  endtask

  // pulse, stall and address capture; lengths are judged as cycle totals
  always @(posedge mclk) begin
    rd_seen <= reg_rd;
    if (nvm_prog === 1'b1) prog_cyc++;
    if (nvm_prog === 1'b1) pa <= nvm_addr;
    if (nvm_prog === 1'b1) pd <= nvm_wdata;
    if (nvm_erase === 1'b1) erase_cyc++;
    if (nvm_erase === 1'b1) ep <= nvm_addr[15:9];
    if (cpu_stall === 1'b1 && irq_hold === 1'b1) hold_cyc++;
  end
  // read data lands the cycle after the strobe; oldest note is its match
  always @(negedge mclk) begin
    if (rd_seen === 1'b1 && expq.size() > 0) check({8'h00, reg_rdata}, {8'h00, expq.pop_front()});
    else if (rd_seen === 1'b1) check(16'h0000, 16'h0001);
  end
  always @(posedge hung) begin
    err_total++;
    $display("unexpected at %0t: stall never ended", $time);
    stop_test();
  end

  initial begin
    {rst, opt_wprot, opt_rprot, ext_rd_req} = 4'h8;
    err_total = 0;
    checks_done = 0;
    prog_cyc = 0;
    erase_cyc = 0;
    hold_cyc = 0;
    void'($urandom(32'hae42b129));
    pg = 7'($urandom_range(111, 0));
    off = 9'($urandom);
    dat = 8'($urandom);
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    rd(`FPE_ADDR_CMD, `FPE_ST_LOCKED);
    wr(`FPE_ADDR_CMD, `FPE_CMD_RESET);
    wr(`FPE_ADDR_CMD, `FPE_CMD_SECSEL);
    rd(`FPE_ADDR_CMD, 8'h04);
    rd(`FPE_ADDR_PAGE, `FPE_LOCK_RST);
    wr(`FPE_ADDR_PAGE, 8'h80);
    wr(`FPE_ADDR_PAGE, 8'h00);
    rd(`FPE_ADDR_PAGE, 8'h80);
    wr(`FPE_ADDR_CMD, `FPE_CMD_RESET);
    wr(`FPE_ADDR_PAGE, 8'h12);
    rd(`FPE_ADDR_PAGE, 8'h12);
    $display("test sector lock done");
    // 100 kHz setting keeps pulses short: program 4, erase 1000 cycles
    wr(`FPE_ADDR_FREQ_HI, 8'h00);
    wr(`FPE_ADDR_FREQ_LO, 8'h64);
    rd(`FPE_ADDR_FREQ_HI, 8'h00);
    rd(`FPE_ADDR_FREQ_LO, 8'h64);
    unlock(pg);
    rd(`FPE_ADDR_CMD, 8'h03);
    {c0, h0} = {prog_cyc, hold_cyc};
    i_core.st({pg, off}, dat);
    rd(`FPE_ADDR_CMD, 8'h03);
    check(16'(prog_cyc - c0), 16'd4);
    check(16'(hold_cyc - h0), 16'd4);
    check(pa, {pg, off});
    check({8'h00, pd}, {8'h00, dat});
    i_core.st({pg + 7'h01, off}, dat);
    wr(`FPE_ADDR_CMD, `FPE_CMD_RESET);
    rd(`FPE_ADDR_CMD, `FPE_ST_LOCKED);
    i_core.st({pg, off}, dat);
    rd(`FPE_ADDR_CMD, `FPE_ST_LOCKED);
    check(16'(prog_cyc - c0), 16'd4);
    $display("test program done");
    wr(`FPE_ADDR_PAGE, {1'b0, pg});
    wr(`FPE_ADDR_CMD, `FPE_CMD_KEY2);
    rd(`FPE_ADDR_CMD, `FPE_ST_LOCKED);
    wr(`FPE_ADDR_CMD, `FPE_CMD_KEY1);
    rd(`FPE_ADDR_CMD, `FPE_ST_LOCKED);
    wr(`FPE_ADDR_CMD, `FPE_CMD_RESET);
    wr(`FPE_ADDR_PAGE, {1'b0, pg});
    wr(`FPE_ADDR_CMD, `FPE_CMD_KEY1);
    wr(`FPE_ADDR_PAGE, {1'b0, pg});
    rd(`FPE_ADDR_CMD, `FPE_ST_LOCKED);
    $display("test order done");
    {c0, e0} = {prog_cyc, erase_cyc};
    unlock(7'h70);
    i_core.st({7'h70, off}, 8'h00);
    wr(`FPE_ADDR_CMD, `FPE_CMD_ERASE);
    opt_wprot <= 1'b1;
    unlock(pg);
    i_core.st({pg, off}, 8'h00);
    wr(`FPE_ADDR_CMD, `FPE_CMD_ERASE);
    opt_wprot <= 1'b0;
    unlock(pg);
    wr(`FPE_ADDR_CMD, `FPE_CMD_MASS);
    rd(`FPE_ADDR_CMD, `FPE_ST_LOCKED);
    check(16'(prog_cyc - c0 + erase_cyc - e0), 16'd0);
    $display("test protection done");
    {e0, h0} = {erase_cyc, hold_cyc};
    unlock(pg);
    wr(`FPE_ADDR_CMD, `FPE_CMD_ERASE);
    rd(`FPE_ADDR_CMD, `FPE_ST_LOCKED);
    check(16'(erase_cyc - e0), 16'd1000);
    check(16'(hold_cyc - h0), 16'd1000);
    check({9'h000, ep}, {9'h000, pg});
    $display("test erase done");
    for (int i = 0; i < 4; i++) begin
      {opt_rprot, ext_rd_req} <= 2'(i);
      @(negedge mclk);
      check({15'h0000, ext_rd_allow}, {15'h0000, i == 1});
      @(posedge mclk);
    end
    $display("test read protect done");
    stop_test();
  end
endmodule
